/* design/psh_start_hold.sv */
`timescale 1ns/1ps
`include "psh_cfg.svh"
module psh_start_hold #(
    parameter int DEB_CYC = `PSH_DEBOUNCE_CYC,
    parameter int RST_DELAY_CYC = `PSH_RST_DELAY_CYC,
    parameter int RAMP_CYC = `PSH_RAMP_CYC,
    parameter int WAKE_CYC = `PSH_WAKE_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start_request_n,
    input wire logic power_hold,
    input wire logic low_power_select,
    output logic start_echo_n_out,
    output logic start_echo_n_oe,
    output logic system_reset_out_n_out,
    output logic system_reset_out_n_oe,
    output logic railsOn,
    output logic memRailOn,
    output logic lowPowerMode,
    output psh_pkg::psh_pstate_t powerState
);
    localparam int TW = $clog2(RST_DELAY_CYC + RAMP_CYC + WAKE_CYC + 2);
    initial
    begin
        if (RST_DELAY_CYC < 1 || RAMP_CYC < 1 || WAKE_CYC < 1)
            $error("timing counts must be at least one");
    end

    logic startLow;
    psh_debounce #(.DEB_CYC(DEB_CYC)) uDeb (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .rawLow(!start_request_n),
        .stableLow(startLow)
    );

    psh_pkg::psh_state_t state_reg, state_next;
    logic [TW-1:0] tmr_reg, tmr_next;
    logic [TW-1:0] wake_reg, wake_next;
    logic holdPrev_reg, holdPrev_next;
    logic first_reg, first_next;
    logic startPrev_reg, startPrev_next;
    logic echo_reg, echo_next;
    logic rstRel_reg, rstRel_next;
    logic rails_reg, rails_next;
    logic mem_reg, mem_next;
    logic lp_reg, lp_next;
    psh_pkg::psh_pstate_t ps_reg, ps_next;
    logic holdRise;
    logic startPress;

    assign holdRise = power_hold && !holdPrev_reg;
    assign startPress = startLow && !startPrev_reg;

    always_comb
    begin
        state_next = state_reg;
        tmr_next = tmr_reg;
        wake_next = wake_reg;
        holdPrev_next = power_hold;
        startPrev_next = startLow;
        first_next = 1'b0;
        case (state_reg)
            psh_pkg::PSH_OFF, psh_pkg::PSH_HIBER:
            begin
                // supply-up with start already low: auto start and wake pulse
                if (first_reg && !start_request_n)
                begin
                    wake_next = TW'(WAKE_CYC);
                    state_next = psh_pkg::PSH_RAMP;
                    tmr_next = TW'(RAMP_CYC);
                end
                // debounced press or hold rising edge starts up
                else if (startPress || holdRise)
                begin
                    state_next = psh_pkg::PSH_RAMP;
                    tmr_next = TW'(RAMP_CYC);
                end
                else if (state_reg == psh_pkg::PSH_OFF && !power_hold && low_power_select)
                    state_next = psh_pkg::PSH_HIBER;
                else if (state_reg == psh_pkg::PSH_HIBER && !low_power_select)
                    state_next = psh_pkg::PSH_OFF;
            end
            psh_pkg::PSH_RAMP:
            begin
                if (tmr_reg == TW'(1))
                begin
                    state_next = psh_pkg::PSH_RSTWAIT;
                    tmr_next = TW'(RST_DELAY_CYC);
                end
                else
                    tmr_next = tmr_reg - TW'(1);
            end
            psh_pkg::PSH_RSTWAIT:
            begin
                if (tmr_reg == TW'(1))
                    state_next = power_hold ? psh_pkg::PSH_RUN : psh_pkg::PSH_SHUT;
                else
                    tmr_next = tmr_reg - TW'(1);
            end
            psh_pkg::PSH_RUN:
            begin
                // presses ignored here; hold low shuts down
                if (!power_hold)
                    state_next = psh_pkg::PSH_SHUT;
            end
            psh_pkg::PSH_SHUT:
                state_next = (low_power_select && power_hold == 1'b0 && !first_reg)
                    ? psh_pkg::PSH_HIBER : psh_pkg::PSH_OFF;
            default:
                state_next = psh_pkg::PSH_OFF;
        endcase
        if (wake_reg != '0)
            wake_next = wake_reg - TW'(1);
    end

    always_comb
    begin
        // echo follows detected start, or the wake pulse
        echo_next = startLow || (wake_next != '0);
        rstRel_next = (state_next == psh_pkg::PSH_RUN);
        rails_next = (state_next == psh_pkg::PSH_RAMP) || (state_next == psh_pkg::PSH_RSTWAIT)
            || (state_next == psh_pkg::PSH_RUN);
        mem_next = rails_next || (state_next == psh_pkg::PSH_HIBER);
        lp_next = (state_next == psh_pkg::PSH_RUN) && low_power_select;
        case (state_next)
            psh_pkg::PSH_RUN:
                ps_next = low_power_select ? psh_pkg::PSH_PS_LOWPWR : psh_pkg::PSH_PS_ACTIVE;
            psh_pkg::PSH_HIBER:
                ps_next = psh_pkg::PSH_PS_HIBER;
            default:
                ps_next = psh_pkg::PSH_PS_OFF;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= psh_pkg::PSH_OFF;
            tmr_reg <= '0;
            wake_reg <= '0;
            holdPrev_reg <= 1'b1;
            startPrev_reg <= 1'b0;
            first_reg <= 1'b1;
            echo_reg <= 1'b0;
            rstRel_reg <= 1'b0;
            rails_reg <= 1'b0;
            mem_reg <= 1'b0;
            lp_reg <= 1'b0;
            ps_reg <= psh_pkg::PSH_PS_OFF;
        end
        else
        begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            wake_reg <= wake_next;
            holdPrev_reg <= holdPrev_next;
            startPrev_reg <= startPrev_next;
            first_reg <= first_next;
            echo_reg <= echo_next;
            rstRel_reg <= rstRel_next;
            rails_reg <= rails_next;
            mem_reg <= mem_next;
            lp_reg <= lp_next;
            ps_reg <= ps_next;
        end
    end

    assign start_echo_n_out = 1'b0;
    assign start_echo_n_oe = echo_reg;
    assign system_reset_out_n_out = 1'b0;
    assign system_reset_out_n_oe = !rstRel_reg;
    assign railsOn = rails_reg;
    assign memRailOn = mem_reg;
    assign lowPowerMode = lp_reg;
    assign powerState = ps_reg;

    sequence relMoment_s;
        state_reg == psh_pkg::PSH_RSTWAIT && tmr_reg == TW'(1);
    endsequence
    hold_check_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        relMoment_s ##0 !power_hold |=> state_reg == psh_pkg::PSH_SHUT ##1 !rails_reg)
        else $error("missing hold did not turn off");
    reset_delay_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(rstRel_reg) |-> $past(state_reg) == psh_pkg::PSH_RSTWAIT)
        else $error("reset released without delay");
    echo_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        startLow && !sys_rst |=> start_echo_n_oe)
        else $error("echo not driven while start low");
    run_ignore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == psh_pkg::PSH_RUN && power_hold |=> state_reg == psh_pkg::PSH_RUN)
        else $error("run state left with hold high");
    hold_restart_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == psh_pkg::PSH_OFF && holdRise |=> state_reg == psh_pkg::PSH_RAMP)
        else $error("hold rise did not restart");
    hold_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == psh_pkg::PSH_RUN && !power_hold |=> ##1 !rails_reg ##0 !rstRel_reg)
        else $error("hold low did not shut down");
    auto_wake_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        first_reg && !start_request_n |=> state_reg == psh_pkg::PSH_RAMP ##0 start_echo_n_oe)
        else $error("no auto start at supply rise");
    stay_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg == psh_pkg::PSH_OFF && !startPress && !holdRise && !first_reg
        |=> state_reg != psh_pkg::PSH_RAMP)
        else $error("started without event");
    state_map_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rstRel_reg |-> powerState == psh_pkg::PSH_PS_ACTIVE || powerState == psh_pkg::PSH_PS_LOWPWR)
        else $error("power state mismatch");
endmodule : psh_start_hold

/* design/psh_cfg.svh */
`ifndef PSH_CFG_SVH
`define PSH_CFG_SVH
// clock rate in kHz
`define PSH_CLK_KHZ 40000
// start input debounce, in microseconds
`define PSH_DEBOUNCE_US 1000
`define PSH_DEBOUNCE_CYC ((`PSH_DEBOUNCE_US * `PSH_CLK_KHZ + 999) / 1000)
// reset release delay, in milliseconds
`define PSH_RST_DELAY_MS 16
`define PSH_RST_DELAY_CYC (`PSH_RST_DELAY_MS * `PSH_CLK_KHZ)
// rail ramp time before the reset delay starts, in microseconds
`define PSH_RAMP_US 100
`define PSH_RAMP_CYC ((`PSH_RAMP_US * `PSH_CLK_KHZ) / 1000)
// wake pulse length on the echo output, in microseconds
`define PSH_WAKE_US 100
`define PSH_WAKE_CYC ((`PSH_WAKE_US * `PSH_CLK_KHZ) / 1000)
`endif

/* design/psh_pkg.sv */
package psh_pkg;
    typedef enum logic [2:0] {
        PSH_OFF = 3'b000,
        PSH_RAMP = 3'b001,
        PSH_RSTWAIT = 3'b010,
        PSH_RUN = 3'b011,
        PSH_HIBER = 3'b100,
        PSH_SHUT = 3'b101
    } psh_state_t;
    typedef enum logic [1:0] {
        PSH_PS_OFF = 2'b00,
        PSH_PS_HIBER = 2'b01,
        PSH_PS_LOWPWR = 2'b10,
        PSH_PS_ACTIVE = 2'b11
    } psh_pstate_t;
endpackage : psh_pkg

/* design/psh_debounce.sv */
`timescale 1ns/1ps
`include "psh_cfg.svh"
module psh_debounce #(
    parameter int DEB_CYC = `PSH_DEBOUNCE_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic rawLow,
    output logic stableLow
);
    localparam int CW = $clog2(DEB_CYC + 1);
    initial
    begin
        if (DEB_CYC < 1)
            $error("debounce count must be at least one");
    end
    logic [CW-1:0] cnt_reg, cnt_next;
    logic stable_reg, stable_next;
    always_comb
    begin
        cnt_next = cnt_reg;
        stable_next = stable_reg;
        if (!rawLow)
        begin
            cnt_next = '0;
            stable_next = 1'b0;
        end
        else if (cnt_reg == CW'(DEB_CYC))
            stable_next = 1'b1;
        else
            cnt_next = cnt_reg + CW'(1);
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cnt_reg <= '0;
            stable_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            stable_reg <= stable_next;
        end
    end
    assign stableLow = stable_reg;
    // low pulses shorter than the interval are ignored
    short_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(stable_reg) |-> $past(rawLow) && (cnt_reg == CW'(DEB_CYC)))
        else $error("debounce fired early");
endmodule : psh_debounce

/* tb/psh_host_model.sv */
`timescale 1ns/1ps
module psh_host_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic railsOn,
    input wire logic [1:0] hostCmd,
    input wire logic [7:0] lagCyc,
    input wire logic useSelfRefresh,
    input wire logic lowPwrRun,
    output logic power_hold,
    output logic low_power_select
);
    logic [7:0] lagCnt;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            power_hold <= 1'b0;
            low_power_select <= 1'b0;
            lagCnt <= 8'h00;
        end
        else
        begin
            case (hostCmd)
                2'h1:
                begin
                    if (railsOn && !power_hold)
                    begin
                        lagCnt <= lagCnt + 8'h01;
                        if (lagCnt >= lagCyc)
                            power_hold <= 1'b1;
                    end
                    else
                    begin
                        lagCnt <= 8'h00;
                        if (power_hold)
                            low_power_select <= lowPwrRun;
                    end
                end
                2'h2:
                begin
                    low_power_select <= useSelfRefresh;
                    if (low_power_select == useSelfRefresh)
                        power_hold <= 1'b0;
                end
                2'h3:
                begin
                    power_hold <= 1'b1;
                    if (power_hold)
                        low_power_select <= lowPwrRun;
                end
                default:
                begin
                end
            endcase
        end
    end
endmodule : psh_host_model

/* tb/tb_pmic_start_power_hold_control.sv */
`timescale 1ns/1ps
module tb_pmic_start_power_hold_control;
    localparam int DEB = 4;
    localparam int RMP = 4;
    localparam int RSTD = 20;
    localparam int WK = 4;
    logic core_clk, sys_rst, start_request_n, power_hold, low_power_select;
    logic echoOut, echoOe, rstOut, rstOe, railsOn, memRailOn, lowPowerMode;
    int relCnt = 0;
    int relBase;
    psh_pkg::psh_pstate_t powerState;
    logic [1:0] hostCmd;
    logic [7:0] lagCyc;
    logic useSelfRefresh, lowPwrRun;
    int n_mismatch, num_checks, seed, n, i;
    psh_start_hold #(.DEB_CYC(DEB), .RST_DELAY_CYC(RSTD), .RAMP_CYC(RMP), .WAKE_CYC(WK)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .start_request_n(start_request_n),
        .power_hold(power_hold), .low_power_select(low_power_select),
        .start_echo_n_out(echoOut), .start_echo_n_oe(echoOe),
        .system_reset_out_n_out(rstOut), .system_reset_out_n_oe(rstOe),
        .railsOn(railsOn), .memRailOn(memRailOn), .lowPowerMode(lowPowerMode),
        .powerState(powerState));
    psh_host_model u_host (.core_clk(core_clk), .sys_rst(sys_rst), .railsOn(railsOn),
        .hostCmd(hostCmd), .lagCyc(lagCyc), .useSelfRefresh(useSelfRefresh),
        .lowPwrRun(lowPwrRun),
        .power_hold(power_hold), .low_power_select(low_power_select));
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // counts reset release cycles so a refused start cannot hide a short glitch
    always @(posedge core_clk)
        if (rstOe === 1'b0)
            relCnt <= relCnt + 1;
    function automatic psh_pkg::psh_pstate_t exp_ps(input logic h, input logic l);
        return h ? (l ? psh_pkg::PSH_PS_LOWPWR : psh_pkg::PSH_PS_ACTIVE)
                 : (l ? psh_pkg::PSH_PS_HIBER : psh_pkg::PSH_PS_OFF);
    endfunction : exp_ps
    function automatic logic sig(input int sel);
        return (sel == 0) ? railsOn : ((sel == 1) ? rstOe : echoOe);
    endfunction : sig
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step
    task automatic wait_sig(input int sel, input logic val, input int lim);
        n = 0;
        while (sig(sel) !== val && n < lim)
        begin
            step(1);
            n++;
        end
    endtask : wait_sig
    task automatic end_test(input int k);
        $display("test %0d done at %0t", k, $time);
    endtask : end_test
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic do_reset(input logic st);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        start_request_n <= st;
        step(5);
        sys_rst <= 1'b0;
    endtask : do_reset
    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        close_out();
    end
    initial
    begin
        sys_rst = 1'b1;
        start_request_n = 1'b1;
        hostCmd = 2'h0;
        lagCyc = 8'h00;
        useSelfRefresh = 1'b0;
        lowPwrRun = 1'b0;
        relBase = 0;
        n_mismatch = 0;
        num_checks = 0;
        seed = 32'hcb82;
        do_reset(1'b1);
        step(60);
        check(railsOn, 1'b0);
        check(powerState, exp_ps(1'b0, 1'b0));
        end_test(1);
        for (i = 0; i < 8; i++)
        begin
            start_request_n <= 1'b0;
            // first pulse lasts exactly the debounce count, one sample short of the DEB + 1 samples that fire it
            step((i == 0) ? DEB : ($unsigned($random(seed)) % DEB) + 1);
            start_request_n <= 1'b1;
            step(($unsigned($random(seed)) % 3) + 1);
            check({railsOn, echoOe}, 2'h0);
        end
        end_test(2);
        lagCyc <= 8'($unsigned($random(seed)) % RSTD);
        hostCmd <= 2'h1;
        start_request_n <= 1'b0;
        wait_sig(0, 1'b1, DEB + 10);
        check({railsOn, echoOe, echoOut, rstOe}, 4'hD);
        start_request_n <= 1'b1;
        wait_sig(2, 1'b0, 4);
        check(echoOe, 1'b0);
        wait_sig(1, 1'b0, RMP + RSTD + 10);
        check({n >= RSTD, rstOe, rstOut}, 3'h4);
        step(3);
        check(powerState, exp_ps(1'b1, 1'b0));
        end_test(3);
        start_request_n <= 1'b0;
        step(DEB + 10);
        check({echoOe, railsOn, rstOe}, 3'h6);
        start_request_n <= 1'b1;
        lowPwrRun <= 1'b1;
        step(5);
        check({powerState, lowPowerMode}, {exp_ps(1'b1, 1'b1), 1'b1});
        end_test(4);
        useSelfRefresh <= 1'b1;
        hostCmd <= 2'h2;
        wait_sig(0, 1'b0, 10);
        step(3);
        check({railsOn, rstOe, memRailOn, lowPowerMode}, 4'h6);
        check(powerState, exp_ps(1'b0, 1'b1));
        lowPwrRun <= 1'b0;
        hostCmd <= 2'h3;
        wait_sig(0, 1'b1, 10);
        check(railsOn, 1'b1);
        wait_sig(1, 1'b0, RMP + RSTD + 10);
        step(3);
        check({rstOe, powerState}, {1'b0, exp_ps(1'b1, 1'b0)});
        end_test(5);
        useSelfRefresh <= 1'b0;
        hostCmd <= 2'h2;
        wait_sig(0, 1'b0, 10);
        step(3);
        check({memRailOn, powerState}, {1'b0, exp_ps(1'b0, 1'b0)});
        hostCmd <= 2'h3;
        wait_sig(0, 1'b1, 10);
        check(railsOn, 1'b1);
        hostCmd <= 2'h2;
        wait_sig(0, 1'b0, RMP + RSTD + 10);
        step(3);
        check({railsOn, rstOe}, 2'h1);
        end_test(6);
        hostCmd <= 2'h0;
        relBase = relCnt;
        start_request_n <= 1'b0;
        wait_sig(0, 1'b1, DEB + 10);
        start_request_n <= 1'b1;
        check(railsOn, 1'b1);
        wait_sig(0, 1'b0, RMP + RSTD + 20);
        check({railsOn, rstOe, relCnt != relBase}, 3'h2);
        end_test(7);
        hostCmd <= 2'h1;
        lagCyc <= 8'h02;
        do_reset(1'b0);
        @(posedge core_clk);
        start_request_n <= 1'b1;
        wait_sig(2, 1'b1, DEB + WK + 10);
        check(echoOe, 1'b1);
        wait_sig(0, 1'b1, 10);
        check(railsOn, 1'b1);
        wait_sig(2, 1'b0, WK + 4);
        check(echoOe, 1'b0);
        end_test(8);
        close_out();
    end
endmodule : tb_pmic_start_power_hold_control
